// ---- include/spiee_pkg.sv ----
/*
  shared constants of the serial nonvolatile memory link: opcodes, status
  layout, protection bounds, link timing and the host's register offsets.
  assumes a 100 mhz system clock on both ends.
*/
package spiee_pkg;
  // ----------------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] WRITE_ARRAY_CMD = 8'h02;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0B;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] PAGE_ERASE_CMD = 8'h42;
  localparam logic [7:0] CHIP_ERASE_CMD = 8'h60;
  localparam logic [7:0] CHIP_ERASE_ALT_CMD = 8'hC7;
  localparam logic [7:0] SLEEP_CMD = 8'hB9;
  localparam logic [7:0] ULTRA_DEEP_SLEEP_CMD = 8'h79;
  localparam logic [7:0] WAKE_CMD = 8'hAB;
  localparam logic [7:0] NO_CMD = 8'h00;
  // ----------------------------------------------------------------------
  // status register layout and array geometry
  // ----------------------------------------------------------------------
  localparam int BUSY_FLAG_BIT = 0;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int BLOCK_PROTECT_LOW_BIT = 2;
  localparam int BLOCK_PROTECT_HIGH_BIT = 3;
  localparam int LOW_POWER_STANDBY_ENABLE_BIT = 5;
  localparam int AUTO_SLEEP_ENABLE_BIT = 6;
  localparam int PROTECT_PIN_ENABLE_BIT = 7;
  localparam logic NV_BIT_RESET = 1'b0;
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int PAGE_BYTES = 32;
  localparam logic [13:0] CHIP_BYTES = 14'h2000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] PROTECT_QUARTER_BASE = 16'h3000;
  localparam logic [15:0] PROTECT_HALF_BASE = 16'h2000;
  localparam logic [15:0] PROTECT_TOP = 16'h3FFF;
  // ----------------------------------------------------------------------
  // link timing and host registers
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_NS = 10;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [1:0] HOST_CTRL_OFS = 2'h0;
  localparam logic [1:0] HOST_TX_OFS = 2'h1;
  localparam logic [1:0] HOST_RX_OFS = 2'h2;
  localparam logic [1:0] HOST_STATUS_OFS = 2'h3;
  localparam int CTRL_MODE3_BIT = 0;
  localparam int CTRL_WP_BIT = 1;
  localparam int CTRL_RELEASE_BIT = 2;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_SELECT_BIT = 1;
endpackage

// ---- include/spiee_if.sv ----
/*
  four-wire serial link plus protect pin between host and memory device.
  assumes the bench instantiates it once and joins both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface spiee_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic wp_n;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;
  // released line floats high through a pull-up
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  modport host (output cs_n, output sck, output sdi, output wp_n, input sdo_line);
  modport device (input cs_n, input sck, input sdi, input wp_n, output sdo, output sdo_oe);
endinterface
`default_nettype wire

// ---- rtl/spiee_device.sv ----
/*
  memory device end: serial command decoder, status register, write
  protection, page buffer and an 8k byte array with a simple erase/program
  engine. assumes link pins are asynchronous to clock_in and that the link
  clock is well below a quarter of clock_in.
*/
// Summary of operation
// - modes 0 and 3, idle clock level
// - sample input rising, drive output falling
// - msb first, opcode starts at select
// - decode the listed opcodes
// - read: opcode, two address bytes, stream
// - fast read adds one dummy byte
// - status byte field layout
// - bit 0 busy, read only
// - bit 1 write latch
// - bits 2,3 block protect, writable
// - bit 5 low power standby enable
// - bit 6 auto sleep enable
// - incomplete write frames are ignored
// - pin low and enable set blocks status write
// - writes need write latch set first
// - block protect region encoding
// - latch clears after completed write, erase and sleep commands, but not after ultra-deep sleep
// - deselected: no input, output released
// - two address bytes, thirteen bits used
`timescale 1ns/100ps
`default_nettype none
module spiee_device (
  input wire logic clock_in,
  input wire logic rst_n_in,
  spiee_if.device link,
  output logic busy_out,
  output logic low_power_out,
  output logic sleep_out
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    PH_OPC = 7'b000_0001,
    PH_AHI = 7'b000_0010,
    PH_ALO = 7'b000_0100,
    PH_DUMMY = 7'b000_1000,
    PH_DIN = 7'b001_0000,
    PH_DOUT = 7'b010_0000,
    PH_SKIP = 7'b100_0000
  } spiee_phase_t;

  typedef struct packed {
    logic sck1, sck2, sck3, cs1, cs2, cs3, sdi1, sdi2, wp1, wp2;
    spiee_phase_t ph;
    logic [7:0] op;
    logic [6:0] rx;
    logic [2:0] nbit;
    logic [12:0] addr;
    logic [5:0] ndat;
    logic [7:0] sdat;
    logic [7:0] tx;
    logic sdo, oe;
    logic wl, busy, bpl, bph, low_power_standby_enable, ase, ppe, asleep, udeep;
    logic [12:0] eptr;
    logic [13:0] erem;
    logic [4:0] eidx;
    logic erase, chip;
    logic lp_o, sl_o;
  } spiee_dev_state_t;

  localparam spiee_dev_state_t DEV_RST = '{ph: PH_SKIP, cs1: 1'b1, cs2: 1'b1,
                                           cs3: 1'b1, wp1: 1'b1, wp2: 1'b1,
                                           default: '0};

  spiee_dev_state_t r, n;
  logic [7:0] mem [0:spiee_pkg::MEM_DEPTH-1];
  logic [7:0] pbuf [0:spiee_pkg::PAGE_BYTES-1];
  logic mem_we, buf_we, rise, fall, cs_fall, cs_rise, ignore;
  logic [12:0] mem_wa, a_full;
  logic [7:0] mem_wd, buf_wd, b;
  logic [4:0] buf_wa;

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] stat_byte(input spiee_dev_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[spiee_pkg::PROTECT_PIN_ENABLE_BIT] = s.ppe;
    v[spiee_pkg::AUTO_SLEEP_ENABLE_BIT] = s.ase;
    v[spiee_pkg::LOW_POWER_STANDBY_ENABLE_BIT] = s.low_power_standby_enable;
    v[spiee_pkg::BLOCK_PROTECT_HIGH_BIT] = s.bph;
    v[spiee_pkg::BLOCK_PROTECT_LOW_BIT] = s.bpl;
    v[spiee_pkg::WRITE_LATCH_BIT] = s.wl;
    v[spiee_pkg::BUSY_FLAG_BIT] = s.busy;
    return v;
  endfunction

  // the region bounds are kept as full 16-bit figures
  function automatic logic protected_at(input logic [12:0] a, input logic bh,
                                        input logic bl);
    logic [15:0] w;
    w = {3'b000, a};
    unique case ({bh, bl})
      2'b00: return 1'b0;
      2'b01: return w >= spiee_pkg::PROTECT_QUARTER_BASE && w <= spiee_pkg::PROTECT_TOP;
      2'b10: return w >= spiee_pkg::PROTECT_HALF_BASE && w <= spiee_pkg::PROTECT_TOP;
      2'b11: return w <= spiee_pkg::PROTECT_TOP;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    mem_we = 1'b0;
    mem_wa = r.eptr;
    mem_wd = spiee_pkg::ERASED_BYTE;
    buf_we = 1'b0;
    buf_wa = r.ndat[4:0];
    buf_wd = 8'h00;
    a_full = 13'h0000;
    ignore = 1'b0;
    n.sck1 = link.sck;
    n.sck2 = r.sck1;
    n.sck3 = r.sck2;
    n.cs1 = link.cs_n;
    n.cs2 = r.cs1;
    n.cs3 = r.cs2;
    n.sdi1 = link.sdi;
    n.sdi2 = r.sdi1;
    n.wp1 = link.wp_n;
    n.wp2 = r.wp1;
    // edges only count while selected, so idle clock level is free
    rise = r.sck2 & ~r.sck3 & ~r.cs2;
    fall = ~r.sck2 & r.sck3 & ~r.cs2;
    cs_fall = ~r.cs2 & r.cs3;
    cs_rise = r.cs2 & ~r.cs3;
    b = {r.rx, r.sdi2};
    // program/erase engine: one byte per clock, protected bytes skipped
    if (r.busy) begin
      mem_we = ~protected_at(r.eptr, r.bph, r.bpl);
      mem_wd = r.erase ? spiee_pkg::ERASED_BYTE : pbuf[r.eidx];
      n.eidx = r.eidx + 5'd1;
      n.eptr = r.chip ? r.eptr + 13'd1 : {r.eptr[12:5], r.eptr[4:0] + 5'd1};
      n.erem = r.erem - 14'd1;
      if (r.erem == 14'd1) begin
        n.busy = 1'b0;
      end
    end
    // a select wakes ultra-deep sleep but that frame itself is dropped
    if (cs_fall) begin
      n.ph = r.udeep ? PH_SKIP : PH_OPC;
      n.udeep = 1'b0;
      n.op = spiee_pkg::NO_CMD;
      n.nbit = 3'd0;
      n.ndat = 6'd0;
    end
    if (rise) begin
      n.rx = b[6:0];
      n.nbit = r.nbit + 3'd1;
      if (r.nbit == 3'd7) begin
        unique case (r.ph)
          PH_OPC: begin
            n.op = b;
            n.ph = PH_SKIP;
            ignore = (r.asleep && b != spiee_pkg::WAKE_CMD) ||
                     (r.busy && b != spiee_pkg::STATUS_READ_CMD);
            if (ignore) begin
              n.op = spiee_pkg::NO_CMD;
            end else begin
              unique case (b)
                spiee_pkg::READ_CMD, spiee_pkg::FAST_READ_CMD: n.ph = PH_AHI;
                spiee_pkg::WRITE_ARRAY_CMD, spiee_pkg::PAGE_ERASE_CMD: begin
                  if (r.wl) n.ph = PH_AHI;
                  else n.op = spiee_pkg::NO_CMD;
                end
                spiee_pkg::STATUS_WRITE_CMD: begin
                  if (r.wl) n.ph = PH_DIN;
                  else n.op = spiee_pkg::NO_CMD;
                end
                spiee_pkg::CHIP_ERASE_CMD, spiee_pkg::CHIP_ERASE_ALT_CMD: begin
                  if (!r.wl) n.op = spiee_pkg::NO_CMD;
                end
                spiee_pkg::STATUS_READ_CMD: begin
                  n.ph = PH_DOUT;
                  n.tx = stat_byte(r);
                end
                default: ;
              endcase
            end
          end
          PH_AHI: begin
            n.addr = {b[4:0], 8'h00};
            n.ph = PH_ALO;
          end
          PH_ALO: begin
            a_full = {r.addr[12:8], b};
            n.addr = a_full;
            n.ph = PH_DIN;
            if (r.op == spiee_pkg::FAST_READ_CMD) begin
              n.ph = PH_DUMMY;
            end else if (r.op == spiee_pkg::READ_CMD) begin
              n.tx = mem[a_full];
              n.addr = a_full + 13'd1;
              n.ph = PH_DOUT;
            end
          end
          PH_DUMMY: begin
            n.tx = mem[r.addr];
            n.addr = r.addr + 13'd1;
            n.ph = PH_DOUT;
          end
          PH_DIN: begin
            if (r.ndat == 6'd0) begin
              n.sdat = b;
            end
            // bytes past a full page are dropped
            if (r.ndat != 6'(spiee_pkg::PAGE_BYTES)) begin
              buf_we = r.op == spiee_pkg::WRITE_ARRAY_CMD;
              buf_wd = b;
              n.ndat = r.ndat + 6'd1;
            end
          end
          PH_DOUT: begin
            if (r.op == spiee_pkg::STATUS_READ_CMD) begin
              n.tx = stat_byte(r);
            end else begin
              n.tx = mem[r.addr];
              n.addr = r.addr + 13'd1;
            end
          end
          PH_SKIP: ;
        endcase
      end
    end
    if (fall && r.ph == PH_DOUT) begin
      n.sdo = r.tx[7];
      n.tx = {r.tx[6:0], 1'b0};
      n.oe = 1'b1;
    end
    // commit on deselect only after whole bytes
    if (cs_rise) begin
      n.oe = 1'b0;
      n.ph = PH_SKIP;
      if (r.nbit == 3'd0) begin
        unique case (r.op)
          spiee_pkg::SET_WRITE_LATCH_CMD: n.wl = 1'b1;
          spiee_pkg::CLEAR_WRITE_LATCH_CMD: n.wl = 1'b0;
          spiee_pkg::STATUS_WRITE_CMD: begin
            if (r.ndat == 6'd1) begin
              n.wl = 1'b0;
              if (!(r.ppe && !r.wp2)) begin
                n.ppe = r.sdat[spiee_pkg::PROTECT_PIN_ENABLE_BIT];
                n.ase = r.sdat[spiee_pkg::AUTO_SLEEP_ENABLE_BIT];
                n.low_power_standby_enable = r.sdat[spiee_pkg::LOW_POWER_STANDBY_ENABLE_BIT];
                n.bph = r.sdat[spiee_pkg::BLOCK_PROTECT_HIGH_BIT];
                n.bpl = r.sdat[spiee_pkg::BLOCK_PROTECT_LOW_BIT];
              end
            end
          end
          spiee_pkg::WRITE_ARRAY_CMD: begin
            if (r.ndat != 6'd0) begin
              n.wl = 1'b0;
              n.busy = 1'b1;
              n.eptr = r.addr;
              n.eidx = 5'd0;
              n.erem = {8'h00, r.ndat};
              n.erase = 1'b0;
              n.chip = 1'b0;
            end
          end
          spiee_pkg::PAGE_ERASE_CMD: begin
            if (r.ph == PH_DIN) begin
              n.wl = 1'b0;
              n.busy = 1'b1;
              n.eptr = {r.addr[12:5], 5'd0};
              n.erem = 14'(spiee_pkg::PAGE_BYTES);
              n.erase = 1'b1;
              n.chip = 1'b0;
            end
          end
          spiee_pkg::CHIP_ERASE_CMD, spiee_pkg::CHIP_ERASE_ALT_CMD: begin
            n.wl = 1'b0;
            n.busy = 1'b1;
            n.eptr = 13'h0000;
            n.erem = spiee_pkg::CHIP_BYTES;
            n.erase = 1'b1;
            n.chip = 1'b1;
          end
          spiee_pkg::SLEEP_CMD: begin
            n.asleep = 1'b1;
            n.wl = 1'b0;
          end
          spiee_pkg::ULTRA_DEEP_SLEEP_CMD: n.udeep = 1'b1;
          spiee_pkg::WAKE_CMD: n.asleep = 1'b0;
          default: ;
        endcase
      end
    end
    n.lp_o = r.cs2 & ~r.busy & r.low_power_standby_enable;
    n.sl_o = r.asleep | r.udeep | (r.cs2 & ~r.busy & r.ase);
  end

  // ----------------------------------------------------------------------
  // registers and storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  // array content survives reset, as a nonvolatile store would
  always_ff @(posedge clock_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (buf_we) begin
      pbuf[buf_wa] <= buf_wd;
    end
  end

  assign link.sdo = r.sdo;
  assign link.sdo_oe = r.oe;
  assign busy_out = r.busy;
  assign low_power_out = r.lp_o;
  assign sleep_out = r.sl_o;
endmodule // spiee_device
`default_nettype wire

// ---- rtl/spiee_host.sv ----
/*
  host end: byte-wide serial master driven by four software registers.
  assumes software frames each command by writing bytes and then releasing
  the select; the link clock is made here by dividing clock_in.
*/
`timescale 1ns/100ps
`default_nettype none
module spiee_host (
  input wire logic clock_in,
  input wire logic rst_n_in,
  spiee_if.host link,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_SETUP = 4'b0010,
    H_LOW = 4'b0100,
    H_HIGH = 4'b1000
  } spiee_hstate_t;

  typedef struct packed {
    logic sdo1, sdo2;
    spiee_hstate_t st;
    logic [2:0] cnt;
    logic [2:0] nbit;
    logic [7:0] tx;
    logic [7:0] rx;
    logic mode3, wp, cs_n, sck, sdi;
    logic [7:0] rdata;
  } spiee_host_state_t;

  localparam spiee_host_state_t HOST_RST = '{st: H_IDLE, wp: 1'b1, cs_n: 1'b1,
                                             default: '0};
  localparam logic [2:0] HALF_LAST = 3'(spiee_pkg::SCK_HALF_CYC - 1);

  spiee_host_state_t r, n;
  logic idle;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    n.rdata = 8'h00;
    n.sdo1 = link.sdo_line;
    n.sdo2 = r.sdo1;
    idle = r.st == H_IDLE;
    if (rd_in) begin
      unique case (addr_in)
        spiee_pkg::HOST_CTRL_OFS: n.rdata = {6'b00_0000, r.wp, r.mode3};
        spiee_pkg::HOST_TX_OFS: n.rdata = r.tx;
        spiee_pkg::HOST_RX_OFS: n.rdata = r.rx;
        spiee_pkg::HOST_STATUS_OFS: n.rdata = {6'b00_0000, ~r.cs_n, ~idle};
      endcase
    end
    if (wr_in && idle) begin
      unique case (addr_in)
        spiee_pkg::HOST_CTRL_OFS: begin
          n.wp = wdata_in[spiee_pkg::CTRL_WP_BIT];
          if (wdata_in[spiee_pkg::CTRL_RELEASE_BIT]) begin
            n.cs_n = 1'b1;
          end
          // mode may only change between frames, where it sets the idle level
          if (r.cs_n) begin
            n.mode3 = wdata_in[spiee_pkg::CTRL_MODE3_BIT];
            n.sck = wdata_in[spiee_pkg::CTRL_MODE3_BIT];
          end
        end
        spiee_pkg::HOST_TX_OFS: begin
          n.tx = wdata_in;
          n.nbit = 3'd0;
          n.cnt = 3'd0;
          n.cs_n = 1'b0;
          n.st = r.cs_n ? H_SETUP : H_LOW;
          if (!r.cs_n) begin
            n.sck = 1'b0;
            n.sdi = wdata_in[7];
          end
        end
        default: ;
      endcase
    end
    unique case (r.st)
      H_IDLE: ;
      H_SETUP: begin
        n.cnt = r.cnt + 3'd1;
        if (r.cnt == HALF_LAST) begin
          n.cnt = 3'd0;
          n.st = H_LOW;
          n.sck = 1'b0;
          n.sdi = r.tx[7];
        end
      end
      H_LOW: begin
        n.cnt = r.cnt + 3'd1;
        if (r.cnt == HALF_LAST) begin
          n.cnt = 3'd0;
          n.st = H_HIGH;
          n.sck = 1'b1;
        end
      end
      H_HIGH: begin
        n.cnt = r.cnt + 3'd1;
        if (r.cnt == HALF_LAST) begin
          n.cnt = 3'd0;
          n.rx = {r.rx[6:0], r.sdo2};
          n.tx = {r.tx[6:0], 1'b0};
          if (r.nbit == 3'd7) begin
            n.st = H_IDLE;
            n.sck = r.mode3;
          end else begin
            n.nbit = r.nbit + 3'd1;
            n.st = H_LOW;
            n.sck = 1'b0;
            n.sdi = r.tx[6];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  assign link.cs_n = r.cs_n;
  assign link.sck = r.sck;
  assign link.sdi = r.sdi;
  assign link.wp_n = r.wp;
  assign rdata_out = r.rdata;
endmodule // spiee_host
`default_nettype wire

// ---- tb/spiee_chk.sv ----
/*
  link checker: clock stillness at select, edge spacing, data stability, output
  release and whole-byte framing.
  assumes the bench hands it the shared link signals and the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module spiee_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  // --------------------------------------------------------------------
  // rising link edges counted per frame
  // --------------------------------------------------------------------
  logic sck_reg;
  logic [2:0] bits_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_reg <= 1'b0;
      bits_reg <= 3'h0;
    end else begin
      sck_reg <= sck;
      if (cs_n) begin
        bits_reg <= 3'h0;
      end else if (sck && !sck_reg) begin
        bits_reg <= bits_reg + 3'h1;
      end
    end
  end
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  a_sck_still_select: assert property (
    $fell(cs_n) |-> $stable(sck) [*3]) else $error("link clock moved at select");
  a_sck_high_len: assert property (
    !cs_n && $rose(sck) |-> sck [*4]) else $error("link clock high phase short");
  a_sck_low_len: assert property (
    !cs_n && $fell(sck) |-> !sck [*4]) else $error("link clock low phase short");
  a_sdi_hold_high: assert property (
    !cs_n && sck && $past(sck) |-> $stable(sdi)) else $error("input data moved while high");
  a_sdo_hold_high: assert property (
    !cs_n && sck && $past(sck) && sdo_oe && $past(sdo_oe) |-> $stable(sdo))
    else $error("output data moved while clock high");
  a_oe_needs_select: assert property (
    $rose(sdo_oe) |-> !cs_n && !$past(cs_n)) else $error("output driven while idle");
  a_oe_idle_off: assert property (
    cs_n [*6] |-> !sdo_oe) else $error("output not released");
  a_whole_bytes: assert property (
    $rose(cs_n) |-> bits_reg == 3'h0) else $error("frame not whole bytes");
  c_read_out: cover property ($rose(sdo_oe));
  c_mode_three: cover property ($fell(cs_n) && sck);
  c_pin_low: cover property ($fell(wp_n) && sdo_line);
endmodule // spiee_chk
`default_nettype wire

// ---- tb/tb_spi_eeprom_command_protect.sv ----
/*
  bench for host and device ends joined by the link interface.
  assumes a 100 mhz clock and frames built from host register writes.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_spi_eeprom_command_protect;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic dev_busy, low_pwr, sleepy, m3, wp;
  // lets a scenario look at the device while its engine still runs
  logic nowait = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int seed = 78;
  logic [7:0] rq[$];
  logic [7:0] d[3];
  logic [7:0] ers[3];
  logic [7:0] s, o, ah, al;
  logic [12:0] a;
  always #5 clock_in = ~clock_in;
  spiee_if lnk ();
  spiee_host i_spiee_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(lnk),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
  spiee_device i_spiee_device (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(lnk),
    .busy_out(dev_busy), .low_power_out(low_pwr), .sleep_out(sleepy));
  spiee_chk chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .cs_n(lnk.cs_n), .sck(lnk.sck),
    .sdi(lnk.sdi), .wp_n(lnk.wp_n), .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe),
    .sdo_line(lnk.sdo_line));
  // --------------------------------------------------------------------
  // register port and frame tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] ad, input logic [7:0] v);
    @(posedge clock_in);
    addr <= ad;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] ad, output logic [7:0] v);
    @(posedge clock_in);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    @(negedge clock_in);
    v = rdata;
  endtask
  // busy polled with a bound; a hang is left to the watchdog
  task automatic frame(input logic [7:0] b[$]);
    logic [7:0] v;
    rq.delete();
    reg_wr(spiee_pkg::HOST_CTRL_OFS, {5'h00, 1'b0, wp, m3});
    foreach (b[i]) begin
      reg_wr(spiee_pkg::HOST_TX_OFS, b[i]);
      for (int k = 0; k < 100; k++) begin
        reg_rd(spiee_pkg::HOST_STATUS_OFS, v);
        if (v[spiee_pkg::HSTAT_BUSY_BIT] === 1'b0) break;
      end
      reg_rd(spiee_pkg::HOST_RX_OFS, v);
      rq.push_back(v);
    end
    reg_wr(spiee_pkg::HOST_CTRL_OFS, {5'h00, 1'b1, wp, m3});
    repeat (8) @(posedge clock_in);
    for (int k = 0; k < 9000 && !nowait && dev_busy !== 1'b0; k++) @(posedge clock_in);
  endtask
  task automatic rdst(output logic [7:0] v);
    frame({spiee_pkg::STATUS_READ_CMD, 8'h00, 8'h00});
    v = rq[1];
    check(rq[2], v);
  endtask
  task automatic write_latch();
    frame({spiee_pkg::SET_WRITE_LATCH_CMD});
  endtask
  task automatic wrst(input logic [7:0] v);
    write_latch();
    frame({spiee_pkg::STATUS_WRITE_CMD, v});
  endtask
  task automatic wr_arr();
    write_latch();
    frame({spiee_pkg::WRITE_ARRAY_CMD, ah, al, d[0], d[1], d[2]});
  endtask
  task automatic rdarr(input logic [7:0] op);
    if (op == spiee_pkg::READ_CMD) frame({op, ah, al, 8'h00, 8'h00, 8'h00});
    else frame({op, ah, al, 8'h00, 8'h00, 8'h00, 8'h00});
    foreach (d[i]) check(rq[rq.size() - 3 + i], d[i]);
  endtask
  // only bits 7,6,5,3,2 take a write; bit 4 reads zero
  function automatic logic [7:0] exp_st(input logic [7:0] w);
    return w & 8'hEC;
  endfunction
  function automatic logic prot(input logic [1:0] bp, input logic [12:0] ad);
    logic [15:0] x;
    x = {3'h0, ad};
    case (bp)
      2'h1: return x >= spiee_pkg::PROTECT_QUARTER_BASE;
      2'h2: return x >= spiee_pkg::PROTECT_HALF_BASE;
      2'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    #900000;
    n_fail++;
    final_report();
  end
  initial begin
    m3 = 1'b0;
    wp = 1'b1;
    ers = '{spiee_pkg::PAGE_ERASE_CMD, spiee_pkg::CHIP_ERASE_CMD, spiee_pkg::CHIP_ERASE_ALT_CMD};
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    rdst(s);
    check(s, 8'h00);
    frame({spiee_pkg::STATUS_WRITE_CMD, 8'h6C});
    rdst(s);
    check(s, 8'h00);
    write_latch();
    rdst(s);
    check(s, 8'h02);
    frame({spiee_pkg::CLEAR_WRITE_LATCH_CMD});
    rdst(s);
    check(s, 8'h00);
    wrst(8'hFF);
    rdst(s);
    check(s, exp_st(8'hFF));
    check({6'h00, sleepy, low_pwr}, 8'h03);
    wp = 1'b0;
    wrst(8'h00);
    rdst(s);
    check(s, exp_st(8'hFF));
    wp = 1'b1;
    wrst(8'h00);
    rdst(s);
    check(s, 8'h00);
    for (int m = 0; m < 2; m++) begin
      m3 = m[0];
      a = 13'($random(seed));
      a[1:0] = 2'h0;
      ah = {3'h0, a[12:8]};
      al = a[7:0];
      foreach (d[i]) d[i] = 8'($random(seed));
      wr_arr();
      rdarr(spiee_pkg::READ_CMD);
      rdarr(spiee_pkg::FAST_READ_CMD);
      frame({spiee_pkg::WRITE_ARRAY_CMD, ah, al, ~d[0]});
      rdarr(spiee_pkg::READ_CMD);
      write_latch();
      frame({spiee_pkg::WRITE_ARRAY_CMD, ah, al});
      rdst(s);
      check(s, 8'h02);
      frame({spiee_pkg::CLEAR_WRITE_LATCH_CMD});
    end
    for (int bp = 1; bp < 4; bp++) begin
      wrst({4'h0, bp[1:0], 2'h0});
      o = 8'($random(seed));
      write_latch();
      frame({spiee_pkg::WRITE_ARRAY_CMD, ah, al, o});
      if (!prot(bp[1:0], a)) d[0] = o;
      rdarr(spiee_pkg::READ_CMD);
    end
    wrst(8'h00);
    foreach (ers[i]) begin
      foreach (d[j]) d[j] = 8'($random(seed));
      wr_arr();
      write_latch();
      if (i == 0) frame({ers[i], ah, al});
      else begin
        nowait = 1'b1;
        frame({ers[i]});
        nowait = 1'b0;
        check({7'h00, dev_busy}, 8'h01);
        rdst(s);
        check(s, 8'h01);
      end
      d = '{spiee_pkg::ERASED_BYTE, spiee_pkg::ERASED_BYTE, spiee_pkg::ERASED_BYTE};
      rdarr(spiee_pkg::READ_CMD);
    end
    write_latch();
    frame({spiee_pkg::SLEEP_CMD});
    check({7'h00, sleepy}, 8'h01);
    rdst(s);
    check(s, 8'hFF);
    frame({spiee_pkg::WAKE_CMD});
    rdst(s);
    check(s, 8'h00);
    frame({spiee_pkg::ULTRA_DEEP_SLEEP_CMD});
    rdst(s);
    check(s, 8'hFF);
    rdst(s);
    check(s, 8'h00);
    final_report();
  end
endmodule // tb_spi_eeprom_command_protect
`default_nettype wire
